// *** design/sgp_regs.vh ***
// Register offsets, field positions, reset values and mode codes of the
// six-pin port.
// Assumes a core that reaches these registers over a plain strobe port.
`ifndef SGP_REGS_VH
`define SGP_REGS_VH

// ========================================
// Register offsets
`define SGP_ADDR_STATUS 8'h03
`define SGP_ADDR_PORT 8'h06
`define SGP_ADDR_DIR 8'h10
`define SGP_ADDR_OPTION 8'h11
`define SGP_ADDR_CTRL 8'h12

// ========================================
// Field positions
`define SGP_STAT_WAKE_BIT 7
`define SGP_OPT_WAKE_DIS_BIT 7
`define SGP_OPT_PU_DIS_BIT 6
`define SGP_CTRL_SLEEP_BIT 0
`define SGP_CTRL_TIMER_CLK_BIT 1
`define SGP_CTRL_MASTER_CLEAR_BIT 2
`define SGP_CTRL_PROG_BIT 3

// ========================================
// Reset values
`define SGP_DIR_RESET 6'h3f
`define SGP_OPTION_RESET 8'hff
`define SGP_CTRL_RESET 8'h04

// ========================================
// Oscillator mode codes
`define SGP_OSC_LOW_POWER_CRYSTAL 2'h0
`define SGP_OSC_CRYSTAL 2'h1
`define SGP_OSC_INTRC 2'h2
`define SGP_OSC_EXTRC 2'h3

// ========================================
// Bus operation codes
`define SGP_OP_NONE 2'h0
`define SGP_OP_BIT_SET 2'h1
`define SGP_OP_BIT_CLEAR 2'h2

`endif

// *** design/sgp_wake_detect.v ***
// Pin-change detector for the wake-capable pins.
// Assumes pin levels synchronous to clock; arms on entry to sleep.
`include "sgp_regs.vh"

module sgp_wake_detect (
	// Clock and reset
	input wire clock,
	input wire rst,
	// Control
	input wire arm,
	input wire enable,
	// Pins watched
	input wire [2:0] pins,
	// Result
	output reg change
);

	reg [2:0] ref_reg;

	// ========================================
	// Reference is taken while not armed, so only later changes count.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_reg <= 3'h0;
			change <= 1'b0;
		end else begin
			if (!arm)
				ref_reg <= pins;
			change <= arm && enable && (pins != ref_reg); // R2
		end
	end

endmodule

// *** design/sgp_port.v ***
// Six-pin port with direction, weak pull-ups, alternates and wake flag.
// Assumes a core on a plain strobe port and pins synchronous to clock.
//
// Operation
// R1: Pins zero, one, three have software-selectable weak pull-ups.
// R2: If enabled, a level change on pins zero, one, three wakes from sleep.
// R3: Pin two is I/O or, alternatively, the external timer clock input.
// R4: Pin three is input only, shared with master clear and Vpp.
// R5: With master clear selected, low on pin three resets the device.
// R6: With master clear selected, pin three pull-up is forced on.
// R7: Pin four is crystal output in the two crystal modes, else I/O.
// R8: Pin five is I/O only in internal RC mode, else clock input.
// R9: In serial programming, pin one is clock, pin zero is data.
// R10: Wake flag bit 7 set by wake reset, cleared by other resets.
// R11: Unimplemented port register bits read as zero.
// R12: Bit set or clear reads pins, modifies, writes all latches.
// R13: Input pins take their sampled level into the latch then.
// R14: External parts must not fight a pin the device drives.
// R15: Writes land at cycle end; reads sample pins at cycle start.
// R16: Direction bit one means input, zero means output.
// R17: Option bits 7 and 6 disable wake-on-change and pull-ups.
//
// Strobed register access was decided locally.
`include "sgp_regs.vh"

module sgp_port (
	// Clock and reset
	input wire clock,
	input wire rst,
	input wire wake_reset,
	// Register port
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr_en,
	input wire rd_en,
	input wire [1:0] rmw_op,
	input wire [2:0] rmw_bit,
	output reg [7:0] rdata,
	// Configuration
	input wire [1:0] osc_mode,
	// Pins
	input wire [5:0] pin_in,
	output wire [5:0] pin_out,
	output wire [5:0] pin_oe,
	output wire [5:0] pullup_en,
	// Alternate functions
	output wire timer_ext_clock_in,
	output wire osc_input,
	output wire osc_pin_output_sel,
	output wire prog_clock,
	output wire prog_data_in,
	output wire master_clear_reset,
	output reg wake_request
);

	reg [5:0] latch_reg;
	reg [5:0] dir_reg;
	reg [7:0] option_reg;
	reg [7:0] ctrl_reg;
	reg wake_flag_reg;
	reg [5:0] pin_sample_reg;
	reg [5:0] rmw_next;
	wire change;
	wire sleeping;
	wire wake_en;
	wire pu_en;
	wire master_clear_en;
	wire prog_mode;
	wire crystal;

	// ========================================
	// Returns the pin image with one bit forced to a value.
	function [5:0] sgp_set_bit;
		input [5:0] img;
		input [2:0] idx;
		input val;
		integer i;
		begin
			sgp_set_bit = img;
			for (i = 0; i < 6; i = i + 1)
				if (idx == i[2:0])
					sgp_set_bit[i] = val;
		end
	endfunction

	assign sleeping = ctrl_reg[`SGP_CTRL_SLEEP_BIT];
	assign master_clear_en = ctrl_reg[`SGP_CTRL_MASTER_CLEAR_BIT];
	assign prog_mode = ctrl_reg[`SGP_CTRL_PROG_BIT];
	assign wake_en = ~option_reg[`SGP_OPT_WAKE_DIS_BIT]; // R17
	assign pu_en = ~option_reg[`SGP_OPT_PU_DIS_BIT]; // R17
	assign crystal = (osc_mode == `SGP_OSC_CRYSTAL) ||
		(osc_mode == `SGP_OSC_LOW_POWER_CRYSTAL);

	// ========================================
	// Pin drivers. Pins one, two, four, five lose drive to their alternates; pin three never drives.
	assign pin_out = {latch_reg[5:4], 1'b0, latch_reg[2:0]};
	assign pin_oe[0] = ~dir_reg[0]; // R16
	assign pin_oe[1] = ~dir_reg[1] & ~prog_mode; // R9
	assign pin_oe[2] = ~dir_reg[2] &
		~ctrl_reg[`SGP_CTRL_TIMER_CLK_BIT]; // R3
	assign pin_oe[3] = 1'b0; // R4
	assign pin_oe[4] = ~dir_reg[4] & ~crystal; // R7
	assign pin_oe[5] = ~dir_reg[5] &
		(osc_mode == `SGP_OSC_INTRC); // R8

	// ========================================
	// Weak pull-ups.
	assign pullup_en[0] = pu_en; // R1
	assign pullup_en[1] = pu_en; // R1
	assign pullup_en[2] = 1'b0;
	assign pullup_en[3] = pu_en | master_clear_en; // R6
	assign pullup_en[4] = 1'b0;
	assign pullup_en[5] = 1'b0;

	// ========================================
	// Alternate function taps.
	assign timer_ext_clock_in = pin_in[2]; // R3
	assign osc_input = pin_in[5]; // R8
	assign osc_pin_output_sel = crystal; // R7
	assign prog_clock = prog_mode & pin_in[1]; // R9
	assign prog_data_in = prog_mode & pin_in[0]; // R9
	// Combinational so the reset acts in the cycle the pin falls.
	assign master_clear_reset = master_clear_en & ~pin_in[3]; // R5

	// ========================================
	// Pins are sampled at the start of the cycle; reads use this image.
	always @(posedge clock or posedge rst) begin
		if (rst)
			pin_sample_reg <= 6'h00;
		else
			pin_sample_reg <= pin_in; // R15
	end

	// Read-modify-write takes every pin level, inputs included.
	always @* begin
		rmw_next = pin_sample_reg; // R12 R13
		if (rmw_op == `SGP_OP_BIT_SET)
			rmw_next = sgp_set_bit(pin_sample_reg, rmw_bit, 1'b1);
		else if (rmw_op == `SGP_OP_BIT_CLEAR)
			rmw_next = sgp_set_bit(pin_sample_reg, rmw_bit, 1'b0);
	end

	// ========================================
	// Register writes land at the clock edge closing the cycle.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			latch_reg <= 6'h00;
			dir_reg <= `SGP_DIR_RESET;
			option_reg <= `SGP_OPTION_RESET;
			ctrl_reg <= `SGP_CTRL_RESET;
		end else begin
			if (wr_en && addr == `SGP_ADDR_PORT &&
				rmw_op != `SGP_OP_NONE)
				latch_reg <= rmw_next; // R12 R13 R15
			else if (wr_en && addr == `SGP_ADDR_PORT)
				latch_reg <= wdata[5:0]; // R15
			if (wr_en && addr == `SGP_ADDR_DIR)
				dir_reg <= wdata[5:0]; // R16
			if (wr_en && addr == `SGP_ADDR_OPTION)
				option_reg <= wdata;
			if (wr_en && addr == `SGP_ADDR_CTRL)
				ctrl_reg <= {4'h0, wdata[3:0]};
			else if (change)
				ctrl_reg[`SGP_CTRL_SLEEP_BIT] <= 1'b0;
		end
	end

	// ========================================
	// Wake flag survives only through the wake reset.
	always @(posedge clock or posedge rst) begin
		if (rst)
			wake_flag_reg <= 1'b0;
		else if (wake_reset)
			wake_flag_reg <= 1'b1; // R10
		else if (wr_en && addr == `SGP_ADDR_STATUS)
			wake_flag_reg <= wdata[`SGP_STAT_WAKE_BIT];
	end

	// The pulse asks the reset controller for a wake reset.
	always @(posedge clock or posedge rst) begin
		if (rst)
			wake_request <= 1'b0;
		else
			wake_request <= change; // R2
	end

	sgp_wake_detect u_wake (
		.clock(clock),
		.rst(rst),
		.arm(sleeping),
		.enable(wake_en),
		.pins({pin_in[3], pin_in[1:0]}),
		.change(change)
	);

	// ========================================
	// Read data, one cycle after the strobe.
	always @(posedge clock or posedge rst) begin
		if (rst)
			rdata <= 8'h00;
		else if (rd_en) begin
			case (addr)
			`SGP_ADDR_PORT: rdata <= {2'h0, pin_sample_reg}; // R11 R15
			`SGP_ADDR_STATUS: rdata <= {wake_flag_reg, 7'h00}; // R10 R11
			`SGP_ADDR_DIR: rdata <= {2'h0, dir_reg}; // R11
			`SGP_ADDR_OPTION: rdata <= option_reg;
			`SGP_ADDR_CTRL: rdata <= ctrl_reg;
			default: rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

endmodule

// *** verif/sgp_board.sv ***
// Board model on the six port pins.
// Assumes the bench drives only pins with ext_en set.
module sgp_board (
	// From the port
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pullup_en,
	// Bench control
	input wire logic [5:0] ext,
	input wire logic [5:0] ext_en,
	// To the port
	output logic [5:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// The board yields wherever the port drives, since contention would
	// damage the pad; loose pins follow pullup_en, high where it is on and low where it is off.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext)
		| (~pin_oe & ~ext_en & pullup_en);
endmodule

// *** verif/sgp_port_checker.sv ***
// Assertions on the ports of the six-pin port.
// Assumes one clock and the asynchronous reset rst.
module sgp_port_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [1:0] rmw_op,
	input wire logic [7:0] rdata,
	// Pins
	input wire logic [1:0] osc_mode,
	input wire logic [5:0] pin_in,
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pullup_en,
	input wire logic timer_ext_clock_in,
	input wire logic osc_input,
	input wire logic osc_pin_output_sel,
	input wire logic prog_clock,
	input wire logic prog_data_in,
	input wire logic master_clear_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence port_wr;
		wr_en && addr == 8'h06 && rmw_op == 2'h0;
	endsequence
	chk_pin3_input: assert property (!pin_oe[3] && !pin_out[3])
		else $error("pin three driven");
	chk_timer_clock: assert property (timer_ext_clock_in == pin_in[2])
		else $error("timer clock not from pin two");
	chk_master_clear: assert property (master_clear_reset |->
		!pin_in[3] && pullup_en[3]) else $error("master clear wrong");
	chk_osc_output: assert property (osc_mode < 2'h2 |-> !pin_oe[4])
		else $error("pin four driven in crystal mode");
	chk_osc_input: assert property (osc_mode != 2'h2 |-> !pin_oe[5])
		else $error("pin five driven outside rc mode");
	chk_prog_clock: assert property (prog_clock |->
		pin_in[1] && !pin_oe[1]) else $error("programming clock wrong");
	chk_prog_data: assert property (prog_clock |->
		prog_data_in == pin_in[0]) else $error("programming data wrong");
	chk_osc_tap: assert property (osc_input == pin_in[5])
		else $error("oscillator input not from pin five");
	chk_crystal_sel: assert property (osc_pin_output_sel ==
		(osc_mode < 2'h2)) else $error("crystal select wrong");
	chk_port_write: assert property (port_wr |=>
		pin_out == ($past(wdata[5:0]) & 6'h37)) else $error("latch wrong");
	chk_port_read: assert property (rd_en && addr == 8'h06 |=>
		rdata == {2'h0, $past(pin_in, 2)}) else $error("port read wrong");
endmodule
bind sgp_port sgp_port_checker chk_i (.clock, .rst, .addr, .wdata, .wr_en,
	.rd_en, .rmw_op, .rdata, .osc_mode, .pin_in, .pin_out, .pin_oe,
	.pullup_en, .timer_ext_clock_in, .osc_input, .osc_pin_output_sel,
	.prog_clock, .prog_data_in, .master_clear_reset);

// *** verif/tb.sv ***
// Directed bench for the six-pin port over its strobe port.
// Assumes the board model on the pins and the bound checker.
`include "sgp_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, rst = 1'b1, wake_reset = 1'b0, wr_en = 1'b0;
	logic rd_en = 1'b0, seen, prog_clock, master_clear_reset, wake_request;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [1:0] rmw_op = 2'h0, osc_mode = `SGP_OSC_INTRC;
	logic [2:0] rmw_bit = 3'h0;
	logic [5:0] ext = 6'h08, ext_en = 6'h08, pin_in, pin_out, pin_oe;
	logic [5:0] pullup_en;
	int error_cnt = 0, cmp_count = 0;
	always #50 clock = ~clock;
	sgp_port DUT (.clock, .rst, .wake_reset, .addr, .wdata, .wr_en, .rd_en,
		.rmw_op, .rmw_bit, .rdata, .osc_mode, .pin_in, .pin_out, .pin_oe,
		.pullup_en, .timer_ext_clock_in(), .osc_input(),
		.osc_pin_output_sel(), .prog_clock, .prog_data_in(),
		.master_clear_reset, .wake_request);
	sgp_board board (.pin_out, .pin_oe, .pullup_en, .ext, .ext_en, .pin_in);
	// ==========
	// Tasks
	task automatic chk(input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d, input logic [1:0] op = 2'h0,
		input logic [2:0] b = 3'h0);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		rmw_op <= op;
		rmw_bit <= b;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========
	// Tests
	initial begin
		#100000;
		error_cnt++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk({2'h0, pin_oe}, 8'h00);
		chk({2'h0, pullup_en}, 8'h08);
		wr(8'h10, 8'h00);
		chk({2'h0, pin_oe}, 8'h37);
		wr(8'h06, 8'h15);
		chk({2'h0, pin_out}, 8'h15);
		rd(8'h06, 8'h1d);
		rd(8'h20, 8'h00);
		ext <= 6'h28;
		ext_en <= 6'h38;
		wr(8'h10, 8'h38);
		wr(8'h06, 8'h00, `SGP_OP_BIT_CLEAR, 3'h5);
		chk({2'h0, pin_out}, 8'h05);
		wr(8'h06, 8'h00, `SGP_OP_BIT_SET, 3'h1);
		chk({2'h0, pin_out}, 8'h27);
		wr(8'h11, 8'hbf);
		chk({2'h0, pullup_en}, 8'h0b);
		ext <= 6'h20;
		#1;
		chk({7'h00, master_clear_reset}, 8'h01);
		wr(8'h12, 8'h0a);
		chk({2'h0, pullup_en}, 8'h0b);
		chk({7'h00, master_clear_reset}, 8'h00);
		chk({2'h0, pin_oe}, 8'h01);
		chk({7'h00, prog_clock}, 8'h01);
		wr(8'h11, 8'hff);
		chk({2'h0, pullup_en}, 8'h00);
		wr(8'h10, 8'h00);
		for (int m = 0; m < 4; m++) begin
			@(posedge clock);
			osc_mode <= m[1:0];
			#1;
			chk({6'h00, pin_oe[5:4]}, {6'h00, m == 2, m >= 2});
		end
		wr(8'h10, 8'h3f);
		wr(8'h11, 8'h3f);
		wr(8'h12, 8'h01);
		ext_en <= 6'h39;
		seen = 1'b0;
		repeat (10) begin
			@(posedge clock);
			#1;
			seen = seen | wake_request;
		end
		chk({7'h00, seen}, 8'h01);
		@(posedge clock);
		wake_reset <= 1'b1;
		@(posedge clock);
		wake_reset <= 1'b0;
		rd(8'h03, 8'h80);
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		rd(8'h03, 8'h00);
		print_verdict;
	end
endmodule
